// ===== logic/rcfr_defines.svh
`ifndef RCFR_DEFINES_SVH
`define RCFR_DEFINES_SVH

// Time base: 50 MHz clock, one tick per millisecond
`define RCFR_CLK_HZ 50000000
`define RCFR_TICK_MS 1
`define RCFR_TICK_CYC ((`RCFR_CLK_HZ / 1000) * `RCFR_TICK_MS)

// Delays and windows in milliseconds
`define RCFR_STARTUP_CC_MS 20000
`define RCFR_OV_RETRY_MS 1000
`define RCFR_OV_WINDOW_MS 60000
`define RCFR_AC_DELAY_MS 10000
`define RCFR_AUX_LEAD_MS 450
`define RCFR_PGW_LEAD_MS 3
`define RCFR_BLINK_HALF_MS 250

// Over-voltage restart budget
`define RCFR_OV_MAX_TRIES 3

// Levels in millivolts
`define RCFR_VPROG_MIN_MV 100
`define RCFR_VPROG_MAX_MV 3000
`define RCFR_VOUT_DEFAULT_MV 52000
`define RCFR_VOUT_LIMIT_MV 10000
`define RCFR_VIN_LOW_MV 80000

// Firmware command code for output setpoint
`define RCFR_CMD_VOUT 8'h21

`endif

// ===== logic/rcfr_pkg.sv
package rcfr_pkg;
   typedef enum {
      RCFR_OFF,
      RCFR_AC_WAIT,
      RCFR_AUX_LEAD,
      RCFR_RUN,
      RCFR_HICCUP,
      RCFR_OV_WAIT,
      RCFR_LATCHED
   } rcfr_state_e;
   typedef logic [15:0] rcfr_ms_t;
endpackage

// ===== logic/rcfr_timebase.sv
`timescale 1ns/1ns
`include "rcfr_defines.svh"

// Free-running millisecond tick shared by every delay and window
module rcfr_timebase #(
   parameter int TICK_CYC = `RCFR_TICK_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   output logic tick
);
   logic [31:0] cnt_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= 32'h0;
      end else if (ce) begin
         if (cnt_q == 32'(TICK_CYC - 1)) begin
            cnt_q <= 32'h0;
         end else begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   assign tick = ce && (cnt_q == 32'(TICK_CYC - 1));
endmodule

// ===== logic/rcfr_ctrl.sv
`timescale 1ns/1ns
`include "rcfr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Hardware control: setpoint follows programming pin when between 0.1 and 3.0 V.
// R2 - Pin open or above 3 V gives the 52 V default setpoint.
// R3 - After firmware setpoint command 0x21 the pin is ignored.
// R4 - Power cycle returns control of each feature to its pin.
// R5 - Hold constant current up to 20 s at start-up, then protect.
// R6 - In limit with output above 10 V, the output LED blinks.
// R7 - In limit below 10 V in restart mode, enter hiccup.
// R8 - Output LED on when unit on, off when off or latched.
// R9 - Over-current and over-temperature restart by default; latch-off selectable.
// R10 - Over-voltage: three restarts 1 s apart within a minute, then latch.
// R11 - Fewer than three shutdowns in a minute clears count, new window.
// R12 - Latched unit restarts when enable pin goes off then on.
// R13 - Latched unit restarts on serial off then on operation command.
// R14 - Host restarts all units by broadcast off/on or shared enable toggle.
// R15 - Host keeps units off 20 to 30 s before turning on.
// R16 - Serial mode waits 10 s after AC returns before output rises.
// R17 - Power-good warning asserts at least 3 ms before output below 40 V.
// R18 - Auxiliary 5 V enabled at least 450 ms before main output regulates.
// R19 - Input LED blinks while AC input is below 80 V.
// R20 - One sticky firmware ownership flag per feature, cleared only by reset.
// R21 - All delays counted from one free-running internal time base.
module rcfr_ctrl #(
   parameter int VW = 17,
   parameter int TICK_CYC = `RCFR_TICK_CYC,
   parameter int STARTUP_CC_MS = `RCFR_STARTUP_CC_MS,
   parameter int OV_RETRY_MS = `RCFR_OV_RETRY_MS,
   parameter int OV_WINDOW_MS = `RCFR_OV_WINDOW_MS,
   parameter int AC_DELAY_MS = `RCFR_AC_DELAY_MS,
   parameter int AUX_LEAD_MS = `RCFR_AUX_LEAD_MS,
   parameter int BLINK_HALF_MS = `RCFR_BLINK_HALF_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [VW-1:0] vprog_mv,
   input wire logic serial_mode,
   input wire logic fw_cmd_valid,
   input wire logic [7:0] fw_cmd_code,
   input wire logic [VW-1:0] fw_vout_mv,
   input wire logic fw_op_on,
   input wire logic fw_op_valid,
   input wire logic enable_pin,
   input wire logic ac_ok,
   input wire logic [VW-1:0] vin_mv,
   input wire logic [VW-1:0] vout_mv,
   input wire logic in_limit,
   input wire logic ocp_fault,
   input wire logic otp_fault,
   input wire logic ovp_fault,
   input wire logic ocp_latch_cfg,
   input wire logic otp_latch_cfg,
   input wire logic restart_mode,
   input wire logic vout_fall_warn,
   output logic [VW-1:0] vout_set_mv,
   output logic main_en,
   output logic cc_hold,
   output logic aux5_en,
   output logic out_led,
   output logic in_led,
   output logic power_good_warning,
   output logic latched,
   output logic fw_owns_vout
);
   ////////////////////////////////////////////////////////////////////////////////
   logic tick;
   rcfr_pkg::rcfr_state_e st_q;
   logic [VW-1:0] vout_set_q;
   logic fw_own_q;
   logic [16:0] st_ms_q;
   logic [16:0] cc_ms_q;
   logic [16:0] win_ms_q;
   logic [1:0] ov_cnt_q;
   logic en_prev_q;
   logic op_off_seen_q;
   logic [8:0] blink_ms_q;
   logic blink_q;
   logic aux_q;
   logic main_q;
   logic pgw_q;
   logic cc_q;
   logic hw_fault;
   logic en_restart;
   logic op_restart;

   // One shared tick drives every count, so windows cannot drift apart
   rcfr_timebase #(.TICK_CYC(TICK_CYC)) u_tb ( // R21
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .tick(tick)
   );

   function automatic logic vprog_valid(input logic [VW-1:0] mv);
      return (mv >= VW'(`RCFR_VPROG_MIN_MV)) && (mv <= VW'(`RCFR_VPROG_MAX_MV));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Firmware ownership; only reset clears it, standing in for power cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fw_own_q <= 1'b0; // R4 R20
      end else if (ce && fw_cmd_valid && fw_cmd_code == `RCFR_CMD_VOUT) begin
         fw_own_q <= 1'b1; // R3 R20
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         vout_set_q <= VW'(`RCFR_VOUT_DEFAULT_MV);
      end else if (ce) begin
         if (fw_cmd_valid && fw_cmd_code == `RCFR_CMD_VOUT) begin
            vout_set_q <= fw_vout_mv; // R3
         end else if (!fw_own_q) begin
            if (vprog_valid(vprog_mv)) begin
               vout_set_q <= vprog_mv; // R1
            end else begin
               vout_set_q <= VW'(`RCFR_VOUT_DEFAULT_MV); // R2
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Restart triggers from a latched state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         en_prev_q <= 1'b0;
         op_off_seen_q <= 1'b0;
      end else if (ce) begin
         en_prev_q <= enable_pin;
         if (fw_op_valid && !fw_op_on) begin
            op_off_seen_q <= 1'b1;
         end else if (fw_op_valid && fw_op_on) begin
            op_off_seen_q <= 1'b0;
         end
      end
   end

   assign en_restart = enable_pin && !en_prev_q; // R12
   assign op_restart = fw_op_valid && fw_op_on && op_off_seen_q; // R13
   assign hw_fault = (ocp_fault && ocp_latch_cfg) || (otp_fault && otp_latch_cfg); // R9

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q <= rcfr_pkg::RCFR_OFF;
         st_ms_q <= 17'h0;
      end else if (ce) begin
         if (tick) begin
            st_ms_q <= st_ms_q + 17'h1;
         end
         unique case (st_q)
            rcfr_pkg::RCFR_OFF: begin
               if (enable_pin && ac_ok) begin
                  st_q <= serial_mode ? rcfr_pkg::RCFR_AC_WAIT : rcfr_pkg::RCFR_AUX_LEAD;
                  st_ms_q <= 17'h0;
               end
            end
            rcfr_pkg::RCFR_AC_WAIT: begin
               if (!ac_ok || !enable_pin) begin
                  st_q <= rcfr_pkg::RCFR_OFF;
               end else if (tick && st_ms_q == 17'(AC_DELAY_MS - 1)) begin
                  st_q <= rcfr_pkg::RCFR_AUX_LEAD; // R16
                  st_ms_q <= 17'h0;
               end
            end
            rcfr_pkg::RCFR_AUX_LEAD: begin
               if (!ac_ok || !enable_pin) begin
                  st_q <= rcfr_pkg::RCFR_OFF;
               end else if (tick && st_ms_q == 17'(AUX_LEAD_MS - 1)) begin
                  st_q <= rcfr_pkg::RCFR_RUN; // R18
                  st_ms_q <= 17'h0;
               end
            end
            rcfr_pkg::RCFR_RUN: begin
               if (!enable_pin || !ac_ok) begin
                  st_q <= rcfr_pkg::RCFR_OFF;
               end else if (hw_fault || (ovp_fault && ov_cnt_q == 2'(`RCFR_OV_MAX_TRIES))) begin
                  st_q <= rcfr_pkg::RCFR_LATCHED; // R9 R10
               end else if (ovp_fault) begin
                  st_q <= rcfr_pkg::RCFR_OV_WAIT; // R10
                  st_ms_q <= 17'h0;
               end else if (ocp_fault || otp_fault) begin
                  st_q <= rcfr_pkg::RCFR_HICCUP; // R9
                  st_ms_q <= 17'h0;
               end else if (!cc_q && in_limit && restart_mode &&
                            vout_mv < VW'(`RCFR_VOUT_LIMIT_MV)) begin
                  st_q <= rcfr_pkg::RCFR_HICCUP; // R7
                  st_ms_q <= 17'h0;
               end
            end
            rcfr_pkg::RCFR_HICCUP, rcfr_pkg::RCFR_OV_WAIT: begin
               if (!enable_pin) begin
                  st_q <= rcfr_pkg::RCFR_OFF;
               end else if (tick && st_ms_q == 17'(OV_RETRY_MS - 1)) begin
                  st_q <= rcfr_pkg::RCFR_AUX_LEAD; // R10
                  st_ms_q <= 17'h0;
               end
            end
            rcfr_pkg::RCFR_LATCHED: begin
               if (en_restart || op_restart) begin
                  st_q <= rcfr_pkg::RCFR_OFF; // R12 R13
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Over-voltage count and its one-minute window
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ov_cnt_q <= 2'h0;
         win_ms_q <= 17'h0;
      end else if (ce) begin
         if (st_q == rcfr_pkg::RCFR_LATCHED) begin
            ov_cnt_q <= 2'h0;
            win_ms_q <= 17'h0;
         end else if (st_q == rcfr_pkg::RCFR_RUN && ovp_fault) begin
            if (ov_cnt_q != 2'(`RCFR_OV_MAX_TRIES)) begin
               ov_cnt_q <= ov_cnt_q + 2'h1; // R10
            end
         end else if (tick && ov_cnt_q != 2'h0) begin
            if (win_ms_q == 17'(OV_WINDOW_MS - 1)) begin
               ov_cnt_q <= 2'h0; // R11
               win_ms_q <= 17'h0;
            end else begin
               win_ms_q <= win_ms_q + 17'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Start-up constant-current grace
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cc_q <= 1'b0;
         cc_ms_q <= 17'h0;
      end else if (ce) begin
         if (st_q == rcfr_pkg::RCFR_AUX_LEAD && tick && st_ms_q == 17'(AUX_LEAD_MS - 1)) begin
            cc_q <= 1'b1; // R5
            cc_ms_q <= 17'h0;
         end else if (st_q != rcfr_pkg::RCFR_RUN) begin
            cc_q <= 1'b0;
         end else if (cc_q && tick) begin
            if (cc_ms_q == 17'(STARTUP_CC_MS - 1)) begin
               cc_q <= 1'b0; // R5
            end else begin
               cc_ms_q <= cc_ms_q + 17'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Indicators and enables
   always_ff @(posedge clk) begin
      if (!resetn) begin
         blink_ms_q <= 9'h0;
         blink_q <= 1'b0;
      end else if (ce && tick) begin
         if (blink_ms_q == 9'(BLINK_HALF_MS - 1)) begin
            blink_ms_q <= 9'h0;
            blink_q <= !blink_q;
         end else begin
            blink_ms_q <= blink_ms_q + 9'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aux_q <= 1'b0;
         main_q <= 1'b0;
         pgw_q <= 1'b0;
      end else if (ce) begin
         aux_q <= ac_ok || aux_q; // R18
         main_q <= (st_q == rcfr_pkg::RCFR_RUN); // R16
         // Analog comparator trips ahead of 40 V by design margin
         pgw_q <= vout_fall_warn || !ac_ok; // R17
      end
   end

   always_comb begin
      if (st_q != rcfr_pkg::RCFR_RUN) begin
         out_led = 1'b0; // R8
      end else if (in_limit && vout_mv > VW'(`RCFR_VOUT_LIMIT_MV)) begin
         out_led = blink_q; // R6
      end else begin
         out_led = 1'b1; // R8
      end
   end

   assign in_led = (vin_mv < VW'(`RCFR_VIN_LOW_MV)) ? blink_q : 1'b1; // R19
   assign vout_set_mv = vout_set_q;
   assign main_en = main_q;
   assign cc_hold = cc_q;
   assign aux5_en = aux_q;
   assign power_good_warning = pgw_q;
   assign latched = (st_q == rcfr_pkg::RCFR_LATCHED);
   assign fw_owns_vout = fw_own_q;

   ////////////////////////////////////////////////////////////////////////////////
   a_fw_own_sticky: assert property (@(posedge clk) disable iff (!resetn) // R20
      fw_own_q |=> fw_own_q) else $error("ownership flag dropped");
   a_pin_ignored: assert property (@(posedge clk) disable iff (!resetn) // R3
      (ce && fw_own_q && !fw_cmd_valid) |=> $stable(vout_set_q)) else $error("pin changed setpoint");
   a_pin_default: assert property (@(posedge clk) disable iff (!resetn) // R2
      (ce && !fw_own_q && !fw_cmd_valid && !vprog_valid(vprog_mv)) |=> vout_set_q == VW'(`RCFR_VOUT_DEFAULT_MV))
      else $error("default not used");
   a_pin_follow: assert property (@(posedge clk) disable iff (!resetn) // R1
      (ce && !fw_own_q && !fw_cmd_valid && vprog_valid(vprog_mv)) |=> vout_set_q == $past(vprog_mv))
      else $error("pin not followed");
   a_led_off_latched: assert property (@(posedge clk) disable iff (!resetn) // R8
      latched |-> !out_led) else $error("led on while latched");
   a_main_off_latch: assert property (@(posedge clk) disable iff (!resetn) // R12
      (ce && latched && !en_restart && !op_restart) |=> latched ##1 !main_en) else $error("latch left");
   a_main_after_aux: assert property (@(posedge clk) disable iff (!resetn) // R18
      $rose(main_en) |-> aux5_en) else $error("main before aux");
   a_hw_fault_latch: assert property (@(posedge clk) disable iff (!resetn) // R9
      (ce && st_q == rcfr_pkg::RCFR_RUN && enable_pin && ac_ok && hw_fault) |=> latched)
      else $error("latch-off not taken");
   a_ov_cnt_max: assert property (@(posedge clk) disable iff (!resetn) // R10
      ov_cnt_q <= 2'(`RCFR_OV_MAX_TRIES)) else $error("ov count overflow");
   // Frozen enable must hold the state, the setpoint and the ownership flag, or the sequence would move without the time base
   a_ce_freeze: assert property (@(posedge clk) disable iff (!resetn) // R21
      !ce |=> $stable(st_q) && $stable(vout_set_q) && $stable(fw_own_q)) else $error("state moved while frozen");
   a_cc_grace: assert property (@(posedge clk) disable iff (!resetn) // R5
      (ce && cc_q && st_q == rcfr_pkg::RCFR_RUN && enable_pin && ac_ok && !ovp_fault && !ocp_fault &&
       !otp_fault) |=> st_q == rcfr_pkg::RCFR_RUN) else $error("grace cut short");
   a_limit_hiccup: assert property (@(posedge clk) disable iff (!resetn) // R7
      (ce && st_q == rcfr_pkg::RCFR_RUN && enable_pin && ac_ok && !ovp_fault && !ocp_fault && !otp_fault &&
       !cc_q && in_limit && restart_mode && vout_mv < VW'(`RCFR_VOUT_LIMIT_MV)) |=> st_q == rcfr_pkg::RCFR_HICCUP)
      else $error("hiccup not entered");
   c_latch: cover property (@(posedge clk) disable iff (!resetn) $rose(latched));
   c_restart: cover property (@(posedge clk) disable iff (!resetn) latched ##1 !latched);
   c_fw_take: cover property (@(posedge clk) disable iff (!resetn) $rose(fw_own_q));
   c_hiccup: cover property (@(posedge clk) disable iff (!resetn) st_q == rcfr_pkg::RCFR_HICCUP);
   c_ov_retry: cover property (@(posedge clk) disable iff (!resetn) st_q == rcfr_pkg::RCFR_OV_WAIT);
endmodule

// ===== tb/rcfr_host.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host side: shared enable pin and serial commands
module rcfr_host #(
   parameter int OFF_CYC = 80
) (
   input wire logic clk,
   output logic enable_pin,
   output logic fw_op_valid,
   output logic fw_op_on,
   output logic fw_cmd_valid,
   output logic [7:0] fw_cmd_code,
   output logic [16:0] fw_vout_mv
);
   // Idle fields carry junk so a design reading them without valid shows up
   initial begin
      enable_pin = 1'b0;
      fw_op_valid = 1'b0;
      fw_op_on = 1'b1;
      fw_cmd_valid = 1'b0;
      fw_cmd_code = 8'hde;
      fw_vout_mv = 17'h15555;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Off time is scaled down with the time base, not the full 20 to 30 s
   task automatic pin_cycle();
      @(negedge clk);
      enable_pin = 1'b0;
      repeat (OFF_CYC) @(negedge clk);
      enable_pin = 1'b1;
   endtask
   task automatic op(input logic on);
      @(negedge clk);
      fw_op_on = on;
      fw_op_valid = 1'b1;
      @(negedge clk);
      fw_op_valid = 1'b0;
      fw_op_on = ~on;
   endtask
   task automatic op_cycle();
      op(1'b0);
      repeat (OFF_CYC) @(negedge clk);
      op(1'b1);
   endtask
   task automatic set_vout(input logic [16:0] mv);
      @(negedge clk);
      fw_cmd_code = 8'h21;
      fw_vout_mv = mv;
      fw_cmd_valid = 1'b1;
      @(negedge clk);
      fw_cmd_valid = 1'b0;
      fw_cmd_code = 8'hde;
      fw_vout_mv = ~mv;
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
   localparam int TC = 4;
   localparam int CCMS = 20, OVR = 5, OVW = 100, ACD = 10, AUXL = 5, BLK = 3;
   logic ce;
   logic clk = 1'b0;
   logic resetn, serial_mode, ac_ok, in_limit, ocp_fault, otp_fault, ovp_fault;
   logic ocp_latch_cfg, otp_latch_cfg, restart_mode, vout_fall_warn;
   logic [16:0] vprog_mv, vin_mv, vout_mv, fw_vout_mv, vout_set_mv, mv;
   logic enable_pin, fw_op_valid, fw_op_on, fw_cmd_valid;
   logic [7:0] fw_cmd_code;
   logic main_en, cc_hold, aux5_en, out_led, in_led, power_good_warning, latched, fw_owns_vout;
   int miscompares = 0;
   int n_checks = 0;
   int cyc;
   int rnd;
   initial forever #10 clk = ~clk;
   rcfr_host host (.clk(clk), .enable_pin(enable_pin), .fw_op_valid(fw_op_valid), .fw_op_on(fw_op_on),
      .fw_cmd_valid(fw_cmd_valid), .fw_cmd_code(fw_cmd_code), .fw_vout_mv(fw_vout_mv));
   // Short counts keep the run small; the TC-scaled bounds below are derived from them, the rest are fixed cycle counts
   rcfr_ctrl #(.TICK_CYC(TC), .STARTUP_CC_MS(CCMS), .OV_RETRY_MS(OVR), .OV_WINDOW_MS(OVW), .AC_DELAY_MS(ACD),
      .AUX_LEAD_MS(AUXL), .BLINK_HALF_MS(BLK)) dut (.clk(clk), .resetn(resetn), .ce(ce), .vprog_mv(vprog_mv),
      .serial_mode(serial_mode), .fw_cmd_valid(fw_cmd_valid), .fw_cmd_code(fw_cmd_code),
      .fw_vout_mv(fw_vout_mv), .fw_op_on(fw_op_on), .fw_op_valid(fw_op_valid), .enable_pin(enable_pin),
      .ac_ok(ac_ok), .vin_mv(vin_mv), .vout_mv(vout_mv), .in_limit(in_limit), .ocp_fault(ocp_fault),
      .otp_fault(otp_fault), .ovp_fault(ovp_fault), .ocp_latch_cfg(ocp_latch_cfg),
      .otp_latch_cfg(otp_latch_cfg), .restart_mode(restart_mode), .vout_fall_warn(vout_fall_warn),
      .vout_set_mv(vout_set_mv), .main_en(main_en), .cc_hold(cc_hold), .aux5_en(aux5_en),
      .out_led(out_led), .in_led(in_led), .power_good_warning(power_good_warning), .latched(latched),
      .fw_owns_vout(fw_owns_vout));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("CHECKS %0d MISCOMPARES %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return main_en;
         1: return cc_hold;
         2: return latched;
         3: return in_led;
         default: return out_led;
      endcase
   endfunction
   // Bounded wait; running out ends the run at once
   task automatic waitf(input int s, input logic v, input int lim);
      int i;
      i = 0;
      while (pick(s) !== v && i < lim) begin
         @(negedge clk);
         i++;
      end
      cyc = i;
      n_checks++;
      if (i >= lim) begin
         miscompares++;
         $display("MISMATCH wait%0d exp %b got %b", s, v, pick(s));
         summarize();
      end
   endtask
   task automatic rst();
      @(negedge clk);
      resetn = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
   endtask
   // Fault pulse: 0 over-current, 1 over-temperature, 2 over-voltage
   task automatic fl(input int k);
      @(negedge clk);
      {ovp_fault, otp_fault, ocp_fault} = 3'b001 << k;
      @(negedge clk);
      {ovp_fault, otp_fault, ocp_fault} = 3'b000;
      waitf(0, 1'b0, 20);
   endtask
   task automatic ov_run(input int n);
      repeat (n) begin
         fl(2);
         waitf(0, 1'b1, 200);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, serial_mode, ac_ok, in_limit, ocp_fault, otp_fault, ovp_fault} = 7'h00;
      {ocp_latch_cfg, otp_latch_cfg, restart_mode, vout_fall_warn} = 4'h0;
      vprog_mv = 17'h0;
      vin_mv = 17'h1d4c0;
      vout_mv = 17'h0cb20;
      ce = 1'b1;
      rnd = $urandom(92222);
      rst();
      chk("setpoint", 17'h0cb20, vout_set_mv);
      chk("main_en", 17'h0, main_en);
      vprog_mv = 17'h00bb9 + 17'($urandom_range(0, 60000));
      repeat (3) @(negedge clk);
      chk("setpoint", 17'h0cb20, vout_set_mv);
      // Clock enable low must freeze the setpoint even with a valid pin level
      ce = 1'b0;
      vprog_mv = 17'h00064 + 17'($urandom_range(0, 2900));
      repeat (3) @(negedge clk);
      chk("frozen", 17'h0cb20, vout_set_mv);
      ce = 1'b1;
      @(negedge clk);
      chk("setpoint", vprog_mv, vout_set_mv);
      mv = 17'h0a410 + 17'($urandom_range(0, 11000));
      host.set_vout(mv);
      @(negedge clk);
      chk("setpoint", mv, vout_set_mv);
      chk("owns", 17'h1, fw_owns_vout);
      vprog_mv = 17'h00064 + 17'($urandom_range(0, 2900));
      repeat (3) @(negedge clk);
      chk("setpoint", mv, vout_set_mv);
      vprog_mv = 17'h0;
      rst();
      chk("owns", 17'h0, fw_owns_vout);
      chk("setpoint", 17'h0cb20, vout_set_mv);
      $display("TEST setpoint done");
      ac_ok = 1'b1;
      host.pin_cycle();
      waitf(0, 1'b1, 100);
      chk("aux5", 17'h1, aux5_en);
      chk("cc_hold", 17'h1, cc_hold);
      waitf(1, 1'b0, 30 * TC);
      chk("cc_time", 17'h1, 17'(cyc >= (CCMS - 1) * TC));
      chk("out_led", 17'h1, out_led);
      $display("TEST startup done");
      serial_mode = 1'b1;
      ac_ok = 1'b0;
      rst();
      ac_ok = 1'b1;
      waitf(0, 1'b1, 40 * TC);
      chk("ac_delay", 17'h1, 17'(cyc >= (ACD + AUXL - 1) * TC));
      serial_mode = 1'b0;
      $display("TEST serial delay done");
      vout_fall_warn = 1'b1;
      @(negedge clk);
      chk("pgw", 17'h1, power_good_warning);
      vout_fall_warn = 1'b0;
      repeat (2) @(negedge clk);
      chk("pgw", 17'h0, power_good_warning);
      vin_mv = 17'h0ea60;
      waitf(3, 1'b0, 10 * TC);
      waitf(3, 1'b1, 10 * TC);
      vin_mv = 17'h1d4c0;
      repeat (2) @(negedge clk);
      chk("in_led", 17'h1, in_led);
      $display("TEST leds done");
      in_limit = 1'b1;
      vout_mv = 17'h09c40;
      waitf(4, 1'b0, 10 * TC);
      waitf(4, 1'b1, 10 * TC);
      restart_mode = 1'b1;
      vout_mv = 17'h01388;
      // Start-up grace may still be running here, so allow its full length
      waitf(0, 1'b0, 30 * TC);
      in_limit = 1'b0;
      vout_mv = 17'h0cb20;
      waitf(0, 1'b1, 200);
      $display("TEST limit done");
      for (int k = 0; k < 2; k++) begin
         fl(k);
         waitf(0, 1'b1, 200);
         chk("latched", 17'h0, latched);
         {otp_latch_cfg, ocp_latch_cfg} = 2'b01 << k;
         fl(k);
         waitf(2, 1'b1, 100);
         {otp_latch_cfg, ocp_latch_cfg} = 2'b00;
         host.pin_cycle();
         waitf(0, 1'b1, 400);
      end
      $display("TEST fault config done");
      rst();
      waitf(0, 1'b1, 400);
      ov_run(3);
      chk("latched", 17'h0, latched);
      fl(2);
      waitf(2, 1'b1, 100);
      chk("out_led", 17'h0, out_led);
      host.pin_cycle();
      waitf(2, 1'b0, 100);
      waitf(0, 1'b1, 400);
      ov_run(3);
      fl(2);
      waitf(2, 1'b1, 100);
      host.op_cycle();
      waitf(2, 1'b0, 100);
      waitf(0, 1'b1, 400);
      $display("TEST over-voltage latch done");
      rst();
      waitf(0, 1'b1, 400);
      ov_run(1);
      repeat ((OVW + 10) * TC) @(negedge clk);
      ov_run(3);
      chk("latched", 17'h0, latched);
      $display("TEST window clear done");
      summarize();
   end
endmodule
